// file: verilog/lsl_pkg.sv
// Operation
// - Status bit 7 reads one while any character in the receive FIFO carries a parity, framing or break flag, and clears only when none remains.
// - Status bit 6 reads one only when both the transmit holding and shift registers are empty.
// - Status bit 5 reads one when the transmit holding register is empty, so that the host may then load up to 64 bytes with the FIFO enabled.
// - Status bit 4 flags a character time of low receive line, and the byte stored for that character is 00.
// - Status bit 3 reads one when the character at the FIFO read position lacked a valid stop bit.
// - Status bit 2 reads one when the character at the FIFO read position failed its parity check.
// - Status bit 1 reads one once a receive overrun has happened.
// - Status bit 0 reads one while the receive FIFO holds a character and zero when it is empty.
// - After reset the data-ready, overrun, parity, framing, break and FIFO-error bits all read zero.
// - Bits 4:2 have no storage of their own and come straight from the flags stored with the next unread entry.
// - A status register read leaves the receive FIFO read pointer where it is.
// - Each receive holding register read advances the receive FIFO read pointer by one entry, except when the FIFO is empty.
// - Bit 0 of the FIFO control register enables both FIFOs when one and disables them when zero, its reset state.
package lsl_pkg;

	localparam int FIFO_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] FIFO_FULL = 7'h40;
	localparam logic [CNT_W-1:0] FIFO_ONE = 7'h01;

	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_RHR = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_LSR = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_FCR = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_ISR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_IMR = 12'h010;

	localparam int LSR_DR = 0;
	localparam int LSR_OE = 1;
	localparam int LSR_PE = 2;
	localparam int LSR_FE = 3;
	localparam int LSR_BI = 4;
	localparam int LSR_THRE = 5;
	localparam int LSR_TEMT = 6;
	localparam int LSR_FERR = 7;

	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;

	localparam int IRQ_W = 4;
	localparam int IRQ_RX = 0;
	localparam int IRQ_OE = 1;
	localparam int IRQ_ERR = 2;
	localparam int IRQ_TEMT = 3;

	localparam logic [7:0] BREAK_BYTE = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic brk;
		logic fe;
		logic pe;
		logic [7:0] data;
	} lsl_entry_t;

	typedef struct packed {
		logic valid;
		lsl_entry_t ch;
	} lsl_rx_char_t;

	typedef struct packed {
		lsl_entry_t [FIFO_DEPTH-1:0] mem;
		logic [PTR_W-1:0] wr;
		logic [PTR_W-1:0] rd;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] errs;
	} lsl_fifo_state_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic fcr_en;
		logic ovr;
		logic [IRQ_W-1:0] isr;
		logic [IRQ_W-1:0] imr;
		logic irq;
		logic temt_prev;
	} lsl_top_state_t;

	localparam lsl_fifo_state_t FIFO_RESET = '0;
	localparam lsl_top_state_t TOP_RESET = '0;

	function automatic logic flagged(input lsl_entry_t e);
		flagged = e.brk | e.fe | e.pe;
	endfunction

endpackage

// file: verilog/lsl_rx_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module lsl_rx_fifo (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic depth_one,
	input wire logic push,
	input wire lsl_pkg::lsl_entry_t push_ch,
	input wire logic pop,
	output lsl_pkg::lsl_entry_t head,
	output logic empty,
	output logic full,
	output logic err_any
);

	lsl_pkg::lsl_fifo_state_t s_q;
	lsl_pkg::lsl_fifo_state_t s_d;
	logic do_push;
	logic do_pop;

	assign empty = (s_q.cnt == '0);
	assign full = (s_q.cnt == (depth_one ? lsl_pkg::FIFO_ONE
		: lsl_pkg::FIFO_FULL));
	assign err_any = (s_q.errs != '0);
	// The head entry is wired out, so a status read sees its flags directly.
	assign head = s_q.mem[s_q.rd];
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	always_comb
	begin
		s_d = s_q;
		if (clear)
		begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.cnt = '0;
			s_d.errs = '0;
		end
		else
		begin
			if (do_push)
			begin
				s_d.mem[s_q.wr] = push_ch;
				s_d.wr = PTR_W_INC(s_q.wr);
			end
			if (do_pop)
				s_d.rd = PTR_W_INC(s_q.rd);
			case ({do_push, do_pop})
				2'b10: s_d.cnt = lsl_pkg::CNT_W'(s_q.cnt + 1'b1);
				2'b01: s_d.cnt = lsl_pkg::CNT_W'(s_q.cnt - 1'b1);
				default: s_d.cnt = s_q.cnt;
			endcase
			// Flagged entries are counted in and out, so bit 7 clears only
			// when the last flagged character has left.
			case ({do_push && lsl_pkg::flagged(push_ch),
				do_pop && lsl_pkg::flagged(head)})
				2'b10: s_d.errs = lsl_pkg::CNT_W'(s_q.errs + 1'b1);
				2'b01: s_d.errs = lsl_pkg::CNT_W'(s_q.errs - 1'b1);
				default: s_d.errs = s_q.errs;
			endcase
		end
	end

	function automatic logic [lsl_pkg::PTR_W-1:0] PTR_W_INC(
		input logic [lsl_pkg::PTR_W-1:0] p);
		PTR_W_INC = lsl_pkg::PTR_W'(p + 1'b1);
	endfunction

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= lsl_pkg::FIFO_RESET;
		else
			s_q <= s_d;
	end

	pop_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		do_pop && !do_push && !clear |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
		else $error("read did not take one entry");
	errs_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_q.errs <= s_q.cnt)
		else $error("error count exceeds fill");

endmodule
`default_nettype wire

// file: verilog/lsl_line_status.sv
`timescale 1ns/1ns
`default_nettype none
module lsl_line_status (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire lsl_pkg::lsl_rx_char_t rx_char,
	input wire logic tx_holding_empty,
	input wire logic tx_shift_empty,
	output logic fifo_enable,
	output logic irq
);

	lsl_pkg::lsl_top_state_t s_q;
	lsl_pkg::lsl_top_state_t s_d;
	lsl_pkg::lsl_entry_t head;
	lsl_pkg::lsl_entry_t push_ent;
	logic fifo_empty;
	logic fifo_full;
	logic err_any;
	logic done;
	logic rd_lsr_done;
	logic rd_rhr_done;
	logic wr_fcr;
	logic fifo_clear;
	logic fifo_pop;
	logic ovr_set;
	logic temt;
	logic [7:0] lsr_w;
	logic [lsl_pkg::IRQ_W-1:0] ev;
	logic [lsl_pkg::IRQ_W-1:0] w1c;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == lsl_pkg::OFF_RHR) || (a == lsl_pkg::OFF_LSR)
			|| (a == lsl_pkg::OFF_FCR) || (a == lsl_pkg::OFF_ISR)
			|| (a == lsl_pkg::OFF_IMR);
	endfunction

	// The slave answers in the second access cycle; side effects happen only
	// at the completing edge, never when the read data is latched.
	assign done = psel && penable && s_q.pready;
	assign rd_lsr_done = done && !pwrite && (paddr == lsl_pkg::OFF_LSR);
	assign rd_rhr_done = done && !pwrite && (paddr == lsl_pkg::OFF_RHR);
	assign wr_fcr = done && pwrite && (paddr == lsl_pkg::OFF_FCR);
	assign fifo_pop = rd_rhr_done;
	// Changing the enable empties the FIFO, so stale depth-one pointers can
	// never be reused at full depth.
	assign fifo_clear = wr_fcr && (pwdata[lsl_pkg::FCR_RXRST]
		|| (pwdata[lsl_pkg::FCR_EN] != s_q.fcr_en));
	assign ovr_set = rx_char.valid && fifo_full;
	assign temt = tx_holding_empty && tx_shift_empty;

	always_comb
	begin
		push_ent = rx_char.ch;
		if (rx_char.ch.brk)
			push_ent.data = lsl_pkg::BREAK_BYTE;
	end

	always_comb
	begin
		lsr_w = 8'h00;
		lsr_w[lsl_pkg::LSR_DR] = !fifo_empty;
		lsr_w[lsl_pkg::LSR_OE] = s_q.ovr;
		lsr_w[lsl_pkg::LSR_PE] = !fifo_empty && head.pe;
		lsr_w[lsl_pkg::LSR_FE] = !fifo_empty && head.fe;
		lsr_w[lsl_pkg::LSR_BI] = !fifo_empty && head.brk;
		lsr_w[lsl_pkg::LSR_THRE] = tx_holding_empty;
		lsr_w[lsl_pkg::LSR_TEMT] = temt;
		lsr_w[lsl_pkg::LSR_FERR] = err_any;
	end

	always_comb
	begin
		ev = '0;
		ev[lsl_pkg::IRQ_RX] = rx_char.valid && !fifo_full;
		ev[lsl_pkg::IRQ_OE] = ovr_set;
		ev[lsl_pkg::IRQ_ERR] = rx_char.valid && !fifo_full
			&& lsl_pkg::flagged(rx_char.ch);
		ev[lsl_pkg::IRQ_TEMT] = temt && !s_q.temt_prev;
		w1c = '0;
		if (done && pwrite && (paddr == lsl_pkg::OFF_ISR))
			w1c = pwdata[lsl_pkg::IRQ_W-1:0];
	end

	always_comb
	begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.temt_prev = temt;
		if (psel && penable && !s_q.pready)
		begin
			s_d.pready = 1'b1;
			s_d.pslverr = !mapped(paddr);
			s_d.prdata = lsl_pkg::READ_ZERO;
			if (!pwrite)
			begin
				case (paddr)
					lsl_pkg::OFF_RHR:
						s_d.prdata[7:0] = fifo_empty ? 8'h00 : head.data;
					lsl_pkg::OFF_LSR:
						s_d.prdata[7:0] = lsr_w;
					lsl_pkg::OFF_FCR:
						s_d.prdata[lsl_pkg::FCR_EN] = s_q.fcr_en;
					lsl_pkg::OFF_ISR:
						s_d.prdata[lsl_pkg::IRQ_W-1:0] = s_q.isr;
					lsl_pkg::OFF_IMR:
						s_d.prdata[lsl_pkg::IRQ_W-1:0] = s_q.imr;
					default:
						s_d.prdata = lsl_pkg::READ_ZERO;
				endcase
			end
		end
		if (wr_fcr)
			s_d.fcr_en = pwdata[lsl_pkg::FCR_EN];
		if (done && pwrite && (paddr == lsl_pkg::OFF_IMR))
			s_d.imr = pwdata[lsl_pkg::IRQ_W-1:0];
		// A new overrun in the clearing cycle is kept, not lost.
		if (rd_lsr_done)
			s_d.ovr = 1'b0;
		if (ovr_set)
			s_d.ovr = 1'b1;
		s_d.isr = (s_q.isr & ~w1c) | ev;
		s_d.irq = |(s_d.isr & s_d.imr);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= lsl_pkg::TOP_RESET;
		else
			s_q <= s_d;
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign fifo_enable = s_q.fcr_en;
	assign irq = s_q.irq;

	// A disabled FIFO keeps one character, as a plain holding register.
	lsl_rx_fifo u_rx_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clear(fifo_clear),
		.depth_one(!s_q.fcr_en),
		.push(rx_char.valid),
		.push_ch(push_ent),
		.pop(fifo_pop),
		.head(head),
		.empty(fifo_empty),
		.full(fifo_full),
		.err_any(err_any)
	);

	sequence lsr_latch_s;
		psel && penable && !s_q.pready && !pwrite
			&& (paddr == lsl_pkg::OFF_LSR);
	endsequence

	ferr_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[7] == $past(err_any))
		else $error("fifo error bit wrong");
	temt_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[6] == $past(temt))
		else $error("transmit empty bit wrong");
	thre_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[5] == $past(tx_holding_empty))
		else $error("holding empty bit wrong");
	break_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_char.valid && rx_char.ch.brk |-> push_ent.data == 8'h00
			&& push_ent.brk)
		else $error("break byte not zero");
	fe_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[3] == $past(!fifo_empty && head.fe))
		else $error("framing bit wrong");
	pe_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[2] == $past(!fifo_empty && head.pe))
		else $error("parity bit wrong");
	ovr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ovr_set |=> s_q.ovr [*1] ##0 (s_q.ovr || $past(rd_lsr_done)))
		else $error("overrun not recorded");
	dr_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[0] == $past(!fifo_empty))
		else $error("data ready bit wrong");
	bi_head_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lsr_latch_s |=> prdata[4] == $past(!fifo_empty && head.brk))
		else $error("break bit not from head");
	lsr_no_pop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_lsr_done |-> !fifo_pop)
		else $error("status read moved pointer");
	fcr_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_fcr |=> fifo_enable == $past(pwdata[0]))
		else $error("fifo enable not written");
	ovr_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_lsr_done && !ovr_set |=> !s_q.ovr ##1 (s_q.ovr == $past(ovr_set)))
		else $error("overrun not cleared by read");
	irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ev != '0 |=> irq == |(s_q.isr & s_q.imr))
		else $error("interrupt level wrong");
	access_ends_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		psel && penable |-> ##[0:1] pready)
		else $error("slave did not answer");

	rhr_pop_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rd_rhr_done && !fifo_empty);
	overrun_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ovr_set ##[1:200] rd_lsr_done);
	err_read_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rd_lsr_done && err_any);
	irq_rise_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(irq));

endmodule
`default_nettype wire

// file: sim/lsl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module lsl_host_model (
	input wire logic ref_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic hang
);
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		hang = 1'h0;
	end

	// The answer is taken at the rising edge that samples pready high, and
	// the request stands unchanged until that edge.
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'h1 && n < 64);
		if (n >= 64)
			hang <= 1'h1;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Released lines show the inverse so stale values cannot pass.
		paddr <= ~a;
		pwdata <= ~wd;
	endtask

	// Status first, then the byte, so the flags belong to that byte.
	task automatic read_char(output logic [31:0] line_status_reg,
		output logic [31:0] receive_holding_register);
		logic e;
		xfer(1'h0, lsl_pkg::OFF_LSR, 32'h0000_0000, line_status_reg, e);
		xfer(1'h0, lsl_pkg::OFF_RHR, 32'h0000_0000, receive_holding_register, e);
	endtask
endmodule
`default_nettype wire

// file: sim/uart_line_status_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uart_line_status_logic_tb;
	typedef struct packed {
		lsl_pkg::lsl_entry_t ch;
		logic the;
		logic tse;
		logic [7:0] line_status_reg;
		logic [7:0] receive_holding_register;
	} lsl_row_t;
	localparam lsl_row_t ROWS [4] = '{
		{3'h0, 8'h5A, 1'h1, 1'h1, 8'h61, 8'h5A},
		{3'h1, 8'h33, 1'h1, 1'h0, 8'hA5, 8'h33},
		{3'h2, 8'hC3, 1'h0, 1'h1, 8'h89, 8'hC3},
		{3'h4, 8'hFF, 1'h0, 1'h0, 8'h91, 8'h00}};
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, hang;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	lsl_pkg::lsl_rx_char_t rx_char = '0;
	logic tx_holding_empty = 1'h0;
	logic tx_shift_empty = 1'h0;
	logic fifo_enable, irq;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] ls, rh;
	logic er;

	always #2 ref_clk = ~ref_clk;

	lsl_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hang(hang));
	lsl_line_status DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_char(rx_char), .tx_holding_empty(tx_holding_empty),
		.tx_shift_empty(tx_shift_empty), .fifo_enable(fifo_enable),
		.irq(irq));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp,
		input string name);
		logic [31:0] d;
		logic e;
		host.xfer(1'h0, a, 32'h0000_0000, d, e);
		check(name, exp, d);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		host.xfer(1'h1, a, d, x, e);
		// The write lands at the completing edge; let its result settle.
		@(negedge ref_clk);
	endtask

	task automatic push(input lsl_pkg::lsl_entry_t c);
		@(posedge ref_clk);
		rx_char <= {1'h1, c};
		@(posedge ref_clk);
		rx_char <= {1'h0, ~c};
	endtask

	always @(posedge hang)
	begin
		fail_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(lsl_pkg::OFF_LSR, 32'h0000_0000, "lsr reset");
		rd(lsl_pkg::OFF_FCR, 32'h0000_0000, "fcr reset");
		check("enable reset", 32'h0, fifo_enable);
		wr(lsl_pkg::OFF_FCR, 32'h0000_0001);
		rd(lsl_pkg::OFF_FCR, 32'h0000_0001, "fcr on");
		check("enable on", 32'h1, fifo_enable);
		$display("test reset done");

		foreach (ROWS[i])
		begin
			tx_holding_empty <= ROWS[i].the;
			tx_shift_empty <= ROWS[i].tse;
			push(ROWS[i].ch);
			host.read_char(ls, rh);
			check("row lsr", ROWS[i].line_status_reg, ls);
			check("row rhr", ROWS[i].receive_holding_register, rh);
			rd(lsl_pkg::OFF_LSR, {ROWS[i].the & ROWS[i].tse, ROWS[i].the, 5'h0},
				"row empty");
		end
		$display("test rows done");

		tx_holding_empty <= 1'h1;
		tx_shift_empty <= 1'h1;
		push({3'h0, 8'h11});
		push({3'h1, 8'h22});
		rd(lsl_pkg::OFF_LSR, 32'h0000_00E1, "err behind");
		rd(lsl_pkg::OFF_LSR, 32'h0000_00E1, "lsr twice");
		rd(lsl_pkg::OFF_RHR, 32'h0000_0011, "first");
		rd(lsl_pkg::OFF_LSR, 32'h0000_00E5, "err head");
		rd(lsl_pkg::OFF_RHR, 32'h0000_0022, "second");
		rd(lsl_pkg::OFF_LSR, 32'h0000_0060, "err gone");
		$display("test error order done");

		for (int i = 0; i < 65; i++)
		begin
			@(posedge ref_clk);
			rx_char <= {1'h1, 3'h0, 8'(i)};
		end
		@(posedge ref_clk);
		rx_char.valid <= 1'h0;
		rd(lsl_pkg::OFF_LSR, 32'h0000_0063, "overrun");
		rd(lsl_pkg::OFF_LSR, 32'h0000_0061, "ovr clear");
		for (int i = 0; i < 64; i++)
			rd(lsl_pkg::OFF_RHR, 32'(i), "fifo order");
		rd(lsl_pkg::OFF_LSR, 32'h0000_0060, "drained");
		$display("test full fifo done");

		wr(lsl_pkg::OFF_FCR, 32'h0000_0000);
		check("enable off", 32'h0, fifo_enable);
		push({3'h0, 8'h44});
		push({3'h0, 8'h55});
		rd(lsl_pkg::OFF_LSR, 32'h0000_0063, "depth one");
		rd(lsl_pkg::OFF_RHR, 32'h0000_0044, "kept char");
		$display("test no fifo done");

		wr(lsl_pkg::OFF_ISR, 32'h0000_000F);
		push({3'h0, 8'h77});
		rd(lsl_pkg::OFF_ISR, 32'h0000_0001, "int status");
		check("irq masked", 32'h0, irq);
		wr(lsl_pkg::OFF_IMR, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		check("irq raised", 32'h1, irq);
		wr(lsl_pkg::OFF_ISR, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		check("irq cleared", 32'h0, irq);
		rd(lsl_pkg::OFF_RHR, 32'h0000_0077, "int char");
		$display("test interrupt done");

		host.xfer(1'h0, 12'h020, 32'h0000_0000, ls, er);
		check("unmapped data", 32'h0000_0000, ls);
		check("unmapped err", 32'h1, er);
		$display("test unmapped done");
		report_and_stop();
	end
endmodule
`default_nettype wire
